// File: i2cm_pkg.sv
/*
 * constants of the serial bus master control and status block: register
 * offsets, field positions, reset values and serial clock timing.
 * assumes a single 20 MHz system clock and a byte-wide register port.
 */
//
// Summary of operation
// - receive full flag goes to 1 when a received byte enters the data register
// - software writes never change the receive full flag
// - reading the receive data register clears the receive full flag
// - interrupt vector write drops the receive interrupt, keeps the full flag
// - no-response fault flag goes to 1 when the slave does not answer
// - no-response fault flag cleared only by a software write, never by hardware
// - speed select 0 gives 100 kHz serial clock, 1 gives 400 kHz
// - halt-after-read makes a stop follow the next received byte
package i2cm_pkg;

   // ************************************************************
   // register offsets
   // ************************************************************
   localparam logic [15:0] CTL_ADDR  = 16'hffc0;
   localparam logic [15:0] RXD_ADDR  = 16'hffc2;
   localparam logic [15:0] IST_ADDR  = 16'hffc4;
   localparam logic [15:0] IMSK_ADDR = 16'hffc5;
   localparam logic [15:0] IVEC_ADDR = 16'hffc6;

   // ************************************************************
   // control and status fields
   // ************************************************************
   localparam int B_RXF   = 7;
   localparam int B_RECEIVE_FULL_IRQ_ENABLE  = 6;
   localparam int B_ERR   = 5;
   localparam int B_FRQ   = 4;
   localparam int B_TXE   = 3;
   localparam int B_SEND_EMPTY_IRQ_ENABLE  = 2;
   localparam int B_HLTRD = 1;
   localparam int B_HLTWR = 0;
   localparam logic [7:0] CTL_RESET = 8'h00;

   // ************************************************************
   // interrupt status and mask fields
   // ************************************************************
   localparam int IRQ_W  = 3;
   localparam int IB_RX  = 0;
   localparam int IB_ERR = 1;
   localparam int IB_TX  = 2;
   localparam logic [IRQ_W-1:0] IRQ_RESET = 3'h0;

   // ************************************************************
   // serial clock timing
   // ************************************************************
   localparam int CLK_HZ      = 20_000_000;
   localparam int SCL_STD_HZ  = 100_000;
   localparam int SCL_FAST_HZ = 400_000;
   localparam int HALF_STD    = CLK_HZ / (2 * SCL_STD_HZ);
   localparam int HALF_FAST   = CLK_HZ / (2 * SCL_FAST_HZ);
   localparam int DIV_W       = 8;

endpackage

// File: i2cm_rate_if.sv
/*
 * link between the control block and the serial clock divider.
 * assumes both ends sit on the system clock.
 */
`timescale 1ns/100ps
interface i2cm_rate_if;
   logic fast;   // speed select level
   logic tick;   // half serial clock period enable

   modport ctl (output fast, input tick);
   modport div (input fast, output tick);
endinterface

// File: i2cm_scl_div.sv
/*
 * serial clock divider: one-cycle enable every half period of the chosen
 * serial clock. assumes the speed level comes from a flop on clk_sys_i.
 */
`timescale 1ns/100ps
module i2cm_scl_div #(
   parameter int HALF_STD  = i2cm_pkg::HALF_STD,
   parameter int HALF_FAST = i2cm_pkg::HALF_FAST
) (
   input  wire logic clk_sys_i,   // system clock
   input  wire logic nrst_i,      // async reset, active low
   i2cm_rate_if.div  rate         // speed in, tick out
);
   localparam int DW = i2cm_pkg::DIV_W;
   logic [DW-1:0] cnt;
   wire  [DW-1:0] lim  = rate.fast ? DW'(HALF_FAST - 1)
                                   : DW'(HALF_STD - 1);
   wire           wrap = (cnt >= lim);

   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cnt       <= '0;
         rate.tick <= 1'b0;
      end else begin
         cnt       <= wrap ? '0 : cnt + 1'b1;
         rate.tick <= wrap;
      end
   end
endmodule

// File: i2cm_ctl.sv
/*
 * control, status and interrupt registers of the serial bus master.
 * assumes the bit engine reports received bytes, sent bytes, loads of the
 * send register and missing acknowledges as one-cycle strobes on clk_sys_i.
 */
`timescale 1ns/100ps
module i2cm_ctl (
   input  wire logic        clk_sys_i,        // system clock, 20 MHz
   input  wire logic        nrst_i,           // async reset, active low
   input  wire logic [15:0] addr_i,           // register address
   input  wire logic [7:0]  wdata_i,          // write data
   input  wire logic        wr_i,             // write strobe
   input  wire logic        rd_i,             // read strobe
   output logic      [7:0]  rdata_o,          // read data, cycle after rd_i
   input  wire logic [7:0]  rx_byte_i,        // byte from bit engine
   input  wire logic        rx_done_i,        // byte received strobe
   input  wire logic        byte_sent_i,      // send byte done strobe
   input  wire logic        tx_load_i,        // send register loaded strobe
   input  wire logic        no_ack_i,         // slave did not answer strobe
   output logic             stop_req_o,       // stop condition request pulse
   output logic             scl_half_tick_o,  // half serial clock enable
   output logic             irq_o             // interrupt, active high level
);
   // ************************************************************
   // address decode
   // ************************************************************
   wire sel_ctl = (addr_i == i2cm_pkg::CTL_ADDR);
   wire sel_rxd = (addr_i == i2cm_pkg::RXD_ADDR);
   wire sel_ist = (addr_i == i2cm_pkg::IST_ADDR);
   wire sel_msk = (addr_i == i2cm_pkg::IMSK_ADDR);
   wire sel_vec = (addr_i == i2cm_pkg::IVEC_ADDR);
   wire ctl_wr  = wr_i && sel_ctl;
   wire ist_wr  = wr_i && sel_ist;
   wire msk_wr  = wr_i && sel_msk;
   wire vec_wr  = wr_i && sel_vec;
   wire rxd_rd  = rd_i && sel_rxd;

   // ************************************************************
   // control and status bits
   // ************************************************************
   logic       receive_holding_full;
   logic       receive_full_irq_enable;
   logic       no_resp_fault;
   logic       bus_speed_select;
   logic       send_holding_empty;
   logic       send_empty_irq_enable;
   logic       halt_after_read;
   logic       halt_after_write;
   logic [7:0] rx_data;
   logic [i2cm_pkg::IRQ_W-1:0] irq_stat;
   logic [i2cm_pkg::IRQ_W-1:0] irq_mask;

   // received byte sets, data read clears, set wins; control writes ignored
   wire next_rxf = rx_done_i ? 1'b1 : (rxd_rd ? 1'b0 : receive_holding_full);
   // hardware only sets; software write may clear, a new fault wins
   wire next_err = no_ack_i ? 1'b1
                 : (ctl_wr ? wdata_i[i2cm_pkg::B_ERR] : no_resp_fault);
   wire next_txe = byte_sent_i ? 1'b1 : (tx_load_i ? 1'b0 : send_holding_empty);
   wire next_stop = (rx_done_i && halt_after_read)
                 || (byte_sent_i && halt_after_write);

   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         receive_holding_full    <= i2cm_pkg::CTL_RESET[i2cm_pkg::B_RXF];
         receive_full_irq_enable <= i2cm_pkg::CTL_RESET[i2cm_pkg::B_RECEIVE_FULL_IRQ_ENABLE];
         no_resp_fault           <= i2cm_pkg::CTL_RESET[i2cm_pkg::B_ERR];
         bus_speed_select        <= i2cm_pkg::CTL_RESET[i2cm_pkg::B_FRQ];
         send_holding_empty      <= i2cm_pkg::CTL_RESET[i2cm_pkg::B_TXE];
         send_empty_irq_enable   <= i2cm_pkg::CTL_RESET[i2cm_pkg::B_SEND_EMPTY_IRQ_ENABLE];
         halt_after_read         <= i2cm_pkg::CTL_RESET[i2cm_pkg::B_HLTRD];
         halt_after_write        <= i2cm_pkg::CTL_RESET[i2cm_pkg::B_HLTWR];
      end else begin
         receive_holding_full <= next_rxf;
         no_resp_fault        <= next_err;
         send_holding_empty   <= next_txe;
         if (ctl_wr) begin
            receive_full_irq_enable <= wdata_i[i2cm_pkg::B_RECEIVE_FULL_IRQ_ENABLE];
            bus_speed_select        <= wdata_i[i2cm_pkg::B_FRQ];
            send_empty_irq_enable   <= wdata_i[i2cm_pkg::B_SEND_EMPTY_IRQ_ENABLE];
            halt_after_read         <= wdata_i[i2cm_pkg::B_HLTRD];
            halt_after_write        <= wdata_i[i2cm_pkg::B_HLTWR];
         end
      end
   end

   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rx_data <= 8'h00;
      end else if (rx_done_i) begin
         rx_data <= rx_byte_i;
      end
   end

   // ************************************************************
   // interrupt status, mask and vector
   // ************************************************************
   wire [i2cm_pkg::IRQ_W-1:0] irq_event;
   wire [i2cm_pkg::IRQ_W-1:0] irq_clr;
   assign irq_event[i2cm_pkg::IB_RX]  = rx_done_i && receive_full_irq_enable;
   assign irq_event[i2cm_pkg::IB_ERR] = no_ack_i;
   assign irq_event[i2cm_pkg::IB_TX]  = byte_sent_i && send_empty_irq_enable;
   // vector write drops both data interrupts, status flags untouched
   wire [i2cm_pkg::IRQ_W-1:0] vec_clr = {vec_wr, 1'b0, vec_wr};
   assign irq_clr = (ist_wr ? wdata_i[i2cm_pkg::IRQ_W-1:0] : '0) | vec_clr;

   genvar gi;
   generate
      for (gi = 0; gi < i2cm_pkg::IRQ_W; gi++) begin : g_irq
         always_ff @(posedge clk_sys_i or negedge nrst_i) begin
            if (!nrst_i) begin
               irq_stat[gi] <= i2cm_pkg::IRQ_RESET[gi];
            end else begin
               irq_stat[gi] <= irq_event[gi] | (irq_stat[gi] & ~irq_clr[gi]);
            end
         end
      end
   endgenerate

   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         irq_mask <= i2cm_pkg::IRQ_RESET;
         irq_o    <= 1'b0;
      end else begin
         if (msk_wr) begin
            irq_mask <= wdata_i[i2cm_pkg::IRQ_W-1:0];
         end
         irq_o <= |(irq_stat & irq_mask);
      end
   end

   // ************************************************************
   // read port and stop request
   // ************************************************************
   wire [7:0] ctl_val = {receive_holding_full, receive_full_irq_enable, no_resp_fault, bus_speed_select,
                         send_holding_empty, send_empty_irq_enable, halt_after_read, halt_after_write};
   wire [7:0] rd_mux  = sel_ctl ? ctl_val
                      : sel_rxd ? rx_data
                      : sel_ist ? {5'h00, irq_stat}
                      : sel_msk ? {5'h00, irq_mask}
                      : 8'h00;

   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rdata_o    <= 8'h00;
         stop_req_o <= 1'b0;
      end else begin
         rdata_o    <= rd_i ? rd_mux : 8'h00;
         stop_req_o <= next_stop;
      end
   end

   // ************************************************************
   // serial clock divider
   // ************************************************************
   i2cm_rate_if rate_bus ();
   assign rate_bus.fast   = bus_speed_select;
   assign scl_half_tick_o = rate_bus.tick;

   i2cm_scl_div #(
      .HALF_STD  (i2cm_pkg::HALF_STD),
      .HALF_FAST (i2cm_pkg::HALF_FAST)
   ) u_div (
      .clk_sys_i (clk_sys_i),
      .nrst_i    (nrst_i),
      .rate      (rate_bus.div)
   );

   // ************************************************************
   // checks
   // ************************************************************
   localparam logic [7:0] GAP_STD  = 8'(i2cm_pkg::HALF_STD - 1);
   localparam logic [7:0] GAP_FAST = 8'(i2cm_pkg::HALF_FAST - 1);
   logic [7:0] tick_gap;
   logic [7:0] speed_age;
   logic       speed_q;
   logic       tick_seen;

   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         tick_gap  <= 8'h00;
         speed_age <= 8'h00;
         speed_q   <= 1'b0;
         tick_seen <= 1'b0;
      end else begin
         tick_gap  <= rate_bus.tick ? 8'h00 : ((tick_gap == 8'hff) ? tick_gap : tick_gap + 8'h01);
         speed_q   <= bus_speed_select;
         speed_age <= (speed_q != bus_speed_select) ? 8'h00
                    : ((speed_age == 8'hff) ? speed_age : speed_age + 8'h01);
         tick_seen <= tick_seen | rate_bus.tick;
      end
   end

   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (!nrst_i);

   chk_rxf_set: assert property (rx_done_i |=> receive_holding_full)
      else $error("receive full flag not set after byte");
   chk_rxf_readonly: assert property (ctl_wr && !rx_done_i && !rxd_rd |=> $stable(receive_holding_full))
      else $error("control write changed receive full flag");
   chk_rxf_clear: assert property (rxd_rd && receive_holding_full && !rx_done_i
                                   |=> !receive_holding_full && rdata_o == $past(rx_data))
      else $error("data read did not clear receive full flag");
   chk_vector_clear: assert property (vec_wr && !rx_done_i
                                      |=> !irq_stat[i2cm_pkg::IB_RX] && $stable(receive_holding_full))
      else $error("vector write handling of receive interrupt wrong");
   chk_rx_irq_gate: assert property ($rose(irq_stat[i2cm_pkg::IB_RX])
                                     |-> $past(rx_done_i) && $past(receive_full_irq_enable))
      else $error("receive interrupt without enabled byte");
   chk_fault_set: assert property (no_ack_i |=> no_resp_fault ##1 (irq_o || !irq_mask[i2cm_pkg::IB_ERR]))
      else $error("no-response fault not flagged");
   chk_fault_sticky: assert property (no_resp_fault && !ctl_wr |=> no_resp_fault)
      else $error("no-response fault cleared without write");
   chk_scl_rate: assert property (rate_bus.tick && tick_seen && speed_age > 8'h64
                                  |-> tick_gap == (bus_speed_select ? GAP_FAST : GAP_STD))
      else $error("serial clock half period wrong");
   chk_halt_read: assert property (rx_done_i && halt_after_read
                                   |=> stop_req_o ##1 (!stop_req_o || $past(next_stop)))
      else $error("no stop after byte with halt after read");

   cov_rx_then_read: cover property (rx_done_i ##[1:20] rxd_rd);
   cov_vector_write: cover property (irq_stat[i2cm_pkg::IB_RX] && vec_wr);
   cov_fault_irq:    cover property (no_ack_i ##2 irq_o);
   cov_stop_read:    cover property (rx_done_i && halt_after_read);
endmodule

// File: i2cm_slave_model.sv
/*
 * far side model: the bit engine and the addressed slave, reporting bytes,
 * sends, send loads and missing answers as one-cycle strobes.
 * assumes clk_sys_i is the controller clock; the bench calls pulse().
 */
`timescale 1ns/100ps
module i2cm_slave_model (
   input  wire logic       clk_sys_i,    // system clock
   output logic      [7:0] rx_byte_o,    // byte from slave
   output logic            rx_done_o,    // byte received strobe
   output logic            byte_sent_o,  // send done strobe
   output logic            tx_load_o,    // send register loaded strobe
   output logic            no_ack_o      // slave silent strobe
);
   initial begin
      rx_byte_o   = 8'hff;
      rx_done_o   = 1'b0;
      byte_sent_o = 1'b0;
      tx_load_o   = 1'b0;
      no_ack_o    = 1'b0;
   end

   // sel 0 byte in, 1 byte sent, 2 send load, 3 no answer
   task automatic pulse(input int sel, input logic [7:0] b);
      @(posedge clk_sys_i);
      rx_byte_o   <= b;
      rx_done_o   <= (sel == 0);
      byte_sent_o <= (sel == 1);
      tx_load_o   <= (sel == 2);
      no_ack_o    <= (sel == 3);
      @(posedge clk_sys_i);
      // released byte lines must not keep the last value
      rx_byte_o   <= ~b;
      rx_done_o   <= 1'b0;
      byte_sent_o <= 1'b0;
      tx_load_o   <= 1'b0;
      no_ack_o    <= 1'b0;
   endtask
endmodule

// File: i2cm_ctl_tb_top.sv
/*
 * bench for the serial bus master control and status block.
 * assumes the far side model drives every bit engine strobe.
 */
`timescale 1ns/100ps
module i2cm_ctl_tb_top;
   logic        clk = 1'b0;
   logic        nrst = 1'b0;
   logic [15:0] addr = 16'h0000;
   logic [7:0]  wdata = 8'h00;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic [7:0]  rdata;
   logic [7:0]  rx_byte;
   logic        rx_done, byte_sent, tx_load, no_ack, stop_req, tick, irq;
   int          n_fail = 0;
   int          checks_done = 0;

   always #25 clk = ~clk;

   i2cm_ctl u_i2cm_ctl (.clk_sys_i(clk), .nrst_i(nrst), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
      .rdata_o(rdata), .rx_byte_i(rx_byte), .rx_done_i(rx_done), .byte_sent_i(byte_sent), .tx_load_i(tx_load),
      .no_ack_i(no_ack), .stop_req_o(stop_req), .scl_half_tick_o(tick), .irq_o(irq));

   i2cm_slave_model u_i2cm_slave_model (.clk_sys_i(clk), .rx_byte_o(rx_byte), .rx_done_o(rx_done),
      .byte_sent_o(byte_sent), .tx_load_o(tx_load), .no_ack_o(no_ack));

   // ************************************************************
   // bus and compare helpers
   // ************************************************************
   task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
      checks_done++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task automatic chk_reg(input string what, input logic [15:0] a, input logic [7:0] exp);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 cmp(what, exp, rdata);
   endtask

   task automatic chk_pin(input string what, input logic exp, input logic got);
      cmp(what, {7'h00, exp}, {7'h00, got});
   endtask

   // ************************************************************
   // scenarios
   // ************************************************************
   task automatic s_reset();
      chk_reg("ctl reset", i2cm_pkg::CTL_ADDR, 8'h00);
      chk_reg("status reset", i2cm_pkg::IST_ADDR, 8'h00);
      chk_reg("mask reset", i2cm_pkg::IMSK_ADDR, 8'h00);
      chk_reg("unmapped read", 16'hffc8, 8'h00);
      chk_pin("irq reset", 1'b0, irq);
   endtask

   task automatic s_rx_flag();
      u_i2cm_slave_model.pulse(0, 8'ha5);
      #1 chk_pin("no stop", 1'b0, stop_req);
      chk_reg("rx full set", i2cm_pkg::CTL_ADDR, 8'h80);
      wr_reg(i2cm_pkg::CTL_ADDR, 8'h00);
      chk_reg("rx full kept", i2cm_pkg::CTL_ADDR, 8'h80);
      chk_reg("rx status off", i2cm_pkg::IST_ADDR, 8'h00);
      chk_reg("rx data", i2cm_pkg::RXD_ADDR, 8'ha5);
      chk_reg("rx full clear", i2cm_pkg::CTL_ADDR, 8'h00);
   endtask

   task automatic s_irq_vec();
      wr_reg(i2cm_pkg::IMSK_ADDR, 8'h01);
      wr_reg(i2cm_pkg::CTL_ADDR, 8'h40);
      u_i2cm_slave_model.pulse(0, 8'h3c);
      @(posedge clk);
      #1 chk_pin("irq raised", 1'b1, irq);
      wr_reg(i2cm_pkg::IVEC_ADDR, 8'h00);
      @(posedge clk);
      #1 chk_pin("irq dropped", 1'b0, irq);
      chk_reg("rx full stays", i2cm_pkg::CTL_ADDR, 8'hc0);
      chk_reg("rx data 2", i2cm_pkg::RXD_ADDR, 8'h3c);
      wr_reg(i2cm_pkg::IMSK_ADDR, 8'h00);
      u_i2cm_slave_model.pulse(0, 8'h11);
      repeat (2) @(posedge clk);
      #1 chk_pin("irq masked", 1'b0, irq);
      chk_reg("status sticky", i2cm_pkg::IST_ADDR, 8'h01);
      wr_reg(i2cm_pkg::IST_ADDR, 8'h01);
      chk_reg("status w1c", i2cm_pkg::IST_ADDR, 8'h00);
      chk_reg("rx data 3", i2cm_pkg::RXD_ADDR, 8'h11);
      wr_reg(i2cm_pkg::CTL_ADDR, 8'h00);
   endtask

   task automatic s_fault();
      wr_reg(i2cm_pkg::IMSK_ADDR, 8'h02);
      u_i2cm_slave_model.pulse(3, 8'h00);
      chk_reg("fault set", i2cm_pkg::CTL_ADDR, 8'h20);
      chk_pin("fault irq", 1'b1, irq);
      repeat (20) @(posedge clk);
      chk_reg("fault held", i2cm_pkg::CTL_ADDR, 8'h20);
      chk_reg("fault status", i2cm_pkg::IST_ADDR, 8'h02);
      wr_reg(i2cm_pkg::CTL_ADDR, 8'h00);
      wr_reg(i2cm_pkg::IST_ADDR, 8'h02);
      chk_reg("fault cleared", i2cm_pkg::CTL_ADDR, 8'h00);
      chk_pin("fault irq off", 1'b0, irq);
      wr_reg(i2cm_pkg::IMSK_ADDR, 8'h00);
   endtask

   task automatic s_speed(input logic [7:0] ctl, input int half);
      int n;
      wr_reg(i2cm_pkg::CTL_ADDR, ctl);
      for (int k = 0; k < 3; k++) begin
         n = 0;
         do begin
            @(posedge clk);
            #1 n++;
         end while (tick !== 1'b1 && n < 300);
      end
      cmp("tick spacing", half[7:0], n[7:0]);
   endtask

   task automatic s_halt();
      wr_reg(i2cm_pkg::CTL_ADDR, 8'h02);
      u_i2cm_slave_model.pulse(0, 8'h5a);
      #1 chk_pin("stop after read", 1'b1, stop_req);
      @(posedge clk);
      #1 chk_pin("stop one cycle", 1'b0, stop_req);
      wr_reg(i2cm_pkg::CTL_ADDR, 8'h01);
      u_i2cm_slave_model.pulse(1, 8'h00);
      #1 chk_pin("stop after write", 1'b1, stop_req);
      chk_reg("send empty", i2cm_pkg::CTL_ADDR, 8'h89);
      u_i2cm_slave_model.pulse(2, 8'h00);
      chk_reg("send loaded", i2cm_pkg::CTL_ADDR, 8'h81);
      chk_reg("rx data 4", i2cm_pkg::RXD_ADDR, 8'h5a);
   endtask

   // ************************************************************
   // run control
   // ************************************************************
   task automatic close_out();
      if (n_fail == 0 && checks_done > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   initial begin
      repeat (3) @(posedge clk);
      nrst <= 1'b1;
      s_reset();
      s_rx_flag();
      s_irq_vec();
      s_fault();
      s_speed(8'h00, 20_000_000 / (2 * 100_000));
      s_speed(8'h10, 20_000_000 / (2 * 400_000));
      s_halt();
      close_out();
   end

   initial begin
      #200us;
      n_fail++;
      close_out();
   end
endmodule
